// [logic/wdt_reset_unit.sv]
// watchdog timer and reset-source control with reset sequencer
// assumes single-cycle register strobes from the core on pclk; pin and analog inputs are asynchronous
`timescale 1ns/10ps
// Behaviour
// R01: DE then AD write disables watchdog
// R02: AD must follow DE within four cycles
// R03: software masks interrupts during disable pair
// R04: FF write locks out disabling until reset
// R05: lock write neither enables nor restarts
// R06: timeout is four power three-plus-n cycles
// R07: interval written only when bit seven clear
// R08: control read gives interval, 111b after reset
// R09: bit six enables/flags convert-start reset
// R10: bit five enables/flags comparator reset
// R11: bit four forces internal reset, flags it
// R12: bit three read-only watchdog reset flag
// R13: bit two enables/flags missing clock detector
// R14: bit one set by power-on reset
// R15: bit zero forces reset driving pin low
// R16: missing clock reset after 100-500 us
// R17: A5 write enables and restarts watchdog
// R18: after reset watchdog runs at maximum interval
// R19: watchdog counter is 21 bits wide
// R20: stay in reset 12 cycles after pin
// R21: unknown bit-seven-set write changes nothing except cancelling a pending DE
// R22: watchdog reset sets only its flag
module wdt_reset_unit #(
  parameter int wdt_base_log2 = wdt_pkg::WDT_BASE_LOG2
) (
  input wire logic pclk,
  input wire logic presetn,
  sfr_if.device sfr,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic convert_start_input,
  input wire logic comparator_zero,
  input wire logic missing_clock_event,
  output logic watchdog_running
);
  logic [1:0] pin_s;
  logic [1:0] cnv_s;
  logic [1:0] cmp_s;
  logic [1:0] mcd_s;
  logic wdt_en;
  logic wdt_lock;
  logic [2:0] interval;
  logic [wdt_pkg::WDT_WIDTH-1:0] wdt_cnt;
  logic arm;
  logic [2:0] arm_age;
  logic [7:0] enables;
  logic [7:0] cause;
  wdt_pkg::rst_state_e state;
  logic [3:0] cnt;
  logic sys_rst;
  logic pin_oe;
  logic [7:0] rdata;
  logic running;
  logic wr_wdt;
  logic wr_rc;
  logic wdt_ovf;
  logic [7:0] int_cause;

  // last count before overflow for interval n
  function automatic logic [wdt_pkg::WDT_WIDTH-1:0] wdt_limit(input logic [2:0] n);
    logic [4:0] sh;
    sh = 5'(wdt_base_log2) + {1'b0, n, 1'b0};
    wdt_limit = (21'h000001 << sh) - 21'h000001;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s <= 2'h3;
      cnv_s <= 2'h3;
      cmp_s <= 2'h3;
      mcd_s <= 2'h0;
    end else begin
      pin_s <= {pin_s[0], rst_pin_in};
      cnv_s <= {cnv_s[0], convert_start_input};
      cmp_s <= {cmp_s[0], comparator_zero};
      mcd_s <= {mcd_s[0], missing_clock_event};
    end
  end

  // register writes are dropped while the system is held in reset
  assign running = (state == wdt_pkg::st_run);
  assign wr_wdt = sfr.wr & running & (sfr.addr == wdt_pkg::WDT_CTRL_ADDR);
  assign wr_rc = sfr.wr & running & (sfr.addr == wdt_pkg::RESET_CAUSE_ADDR);
  // compare, not equality: a lowered interval must not wait for a counter wrap
  assign wdt_ovf = wdt_en & (wdt_cnt >= wdt_limit(interval)); // R06

  // watchdog command decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_en <= 1'b1;
      wdt_lock <= 1'b0;
      interval <= wdt_pkg::INTERVAL_RESET;
      arm <= 1'b0;
      arm_age <= 3'h0;
    end else if (!running) begin
      wdt_en <= 1'b1; // R18
      wdt_lock <= 1'b0; // R04
      interval <= wdt_pkg::INTERVAL_RESET; // R08
      arm <= 1'b0;
      arm_age <= 3'h0;
    end else begin
      if (arm && arm_age != 3'h7) begin
        arm_age <= arm_age + 3'h1;
      end
      if (wr_wdt) begin
        arm <= 1'b0;
        unique case (sfr.wdata)
          wdt_pkg::CODE_ENABLE: begin
            wdt_en <= 1'b1; // R17
          end
          wdt_pkg::CODE_DISABLE_1: begin
            arm <= 1'b1; // R01
            arm_age <= 3'h0;
          end
          wdt_pkg::CODE_DISABLE_2: begin
            // pair too far apart or locked: ignored
            if (arm && arm_age < wdt_pkg::DISABLE_WINDOW && !wdt_lock) begin // R02
              wdt_en <= 1'b0; // R01
            end
          end
          wdt_pkg::CODE_LOCK: begin
            wdt_lock <= 1'b1; // R04 R05
          end
          default: begin
            if (!sfr.wdata[wdt_pkg::INTERVAL_GATE_BIT]) begin // R07 R21
              interval <= sfr.wdata[wdt_pkg::INTERVAL_MSB:wdt_pkg::INTERVAL_LSB]; // R06
            end
          end
        endcase
      end
    end
  end

  // watchdog counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt <= '0;
    end else if (!running || (wr_wdt && sfr.wdata == wdt_pkg::CODE_ENABLE)) begin
      wdt_cnt <= '0; // R17 R18
    end else if (wdt_en) begin
      wdt_cnt <= wdt_cnt + 21'h000001; // R19
    end
  end

  // source enables, cleared by every system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables <= 8'h00;
    end else if (!running) begin
      enables <= 8'h00;
    end else if (wr_rc) begin
      enables <= sfr.wdata & wdt_pkg::MASK_ENABLES; // R09 R10 R13
    end
  end

  // internal sources in fixed priority; whole cause replaced so only one flag stands
  always_comb begin
    int_cause = 8'h00;
    if ((enables & wdt_pkg::MASK_CNV) != 8'h00 && !cnv_s[1]) begin
      int_cause = wdt_pkg::MASK_CNV; // R09
    end else if ((enables & wdt_pkg::MASK_CMP) != 8'h00 && !cmp_s[1]) begin
      int_cause = wdt_pkg::MASK_CMP; // R10
    end else if ((enables & wdt_pkg::MASK_MCD) != 8'h00 && mcd_s[1]) begin
      int_cause = wdt_pkg::MASK_MCD; // R13 R16
    end else if (wdt_ovf) begin
      int_cause = wdt_pkg::MASK_WDT; // R22
    end else if (wr_rc && (sfr.wdata & wdt_pkg::MASK_SW) != 8'h00) begin
      int_cause = wdt_pkg::MASK_SW; // R11
    end
  end

  // reset sequencer; cause survives its own resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= wdt_pkg::st_stretch;
      cnt <= 4'h0;
      cause <= wdt_pkg::CAUSE_RESET; // R14
      sys_rst <= 1'b1;
      pin_oe <= 1'b0;
    end else begin
      unique case (state)
        wdt_pkg::st_run: begin
          cnt <= 4'h0;
          if (!pin_s[1]) begin
            state <= wdt_pkg::st_hold;
            cause <= wdt_pkg::MASK_PIN; // R15
            sys_rst <= 1'b1;
          end else if (wr_rc && (sfr.wdata & wdt_pkg::MASK_PIN) != 8'h00) begin
            state <= wdt_pkg::st_hold;
            cause <= wdt_pkg::MASK_POR; // R14 R15
            pin_oe <= 1'b1; // R15
            sys_rst <= 1'b1;
          end else if (int_cause != 8'h00) begin
            state <= wdt_pkg::st_stretch;
            cause <= int_cause; // R12 R22
            sys_rst <= 1'b1;
          end
        end
        wdt_pkg::st_hold: begin
          // own drive of the pin is released before its level is trusted again
          if (pin_oe) begin
            cnt <= cnt + 4'h1;
            if (cnt == wdt_pkg::PIN_DRIVE_CYCLES - 4'h1) begin
              pin_oe <= 1'b0;
            end
          end else if (pin_s[1]) begin
            state <= wdt_pkg::st_stretch;
            cnt <= 4'h0;
          end
        end
        wdt_pkg::st_stretch: begin
          cnt <= cnt + 4'h1;
          if (cnt == wdt_pkg::PIN_STRETCH_CYCLES - 4'h1) begin // R20
            state <= wdt_pkg::st_run;
            sys_rst <= 1'b0;
          end
        end
        default: begin
          state <= wdt_pkg::st_stretch;
          cnt <= 4'h0;
          sys_rst <= 1'b1;
          pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
    end else if (sfr.rd) begin
      if (sfr.addr == wdt_pkg::WDT_CTRL_ADDR) begin
        rdata <= {5'h00, interval}; // R08
      end else if (sfr.addr == wdt_pkg::RESET_CAUSE_ADDR) begin
        rdata <= {1'b0, cause[6:0]}; // R12
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_running <= 1'b1;
    end else begin
      watchdog_running <= wdt_en;
    end
  end

  assign sfr.rdata = rdata;
  assign sfr.sys_reset = sys_rst;
  assign rst_pin_oe = pin_oe;
  // open drain: only ever pulls low
  assign rst_pin_out = 1'b0;
endmodule

// [logic/wdt_pkg.sv]
// constants for the watchdog and reset-cause unit and its processor-side bridge
// assumes one 250 MHz clock shared by both ends
package wdt_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // special function register addresses
  localparam logic [7:0] WDT_CTRL_ADDR = 8'hFF;
  localparam logic [7:0] RESET_CAUSE_ADDR = 8'hEF;
  // watchdog control codes
  localparam logic [7:0] CODE_ENABLE = 8'hA5;
  localparam logic [7:0] CODE_DISABLE_1 = 8'hDE;
  localparam logic [7:0] CODE_DISABLE_2 = 8'hAD;
  localparam logic [7:0] CODE_LOCK = 8'hFF;
  localparam int INTERVAL_LSB = 0;
  localparam int INTERVAL_MSB = 2;
  localparam int INTERVAL_GATE_BIT = 7;
  localparam logic [2:0] DISABLE_WINDOW = 3'h4;
  localparam logic [2:0] INTERVAL_RESET = 3'h7;
  localparam int WDT_WIDTH = 21;
  localparam int WDT_BASE_LOG2 = 6;
  // reset cause masks
  localparam logic [7:0] MASK_CNV = 8'h40;
  localparam logic [7:0] MASK_CMP = 8'h20;
  localparam logic [7:0] MASK_SW = 8'h10;
  localparam logic [7:0] MASK_WDT = 8'h08;
  localparam logic [7:0] MASK_MCD = 8'h04;
  localparam logic [7:0] MASK_POR = 8'h02;
  localparam logic [7:0] MASK_PIN = 8'h01;
  localparam logic [7:0] MASK_ENABLES = 8'h64;
  localparam logic [7:0] CAUSE_RESET = 8'h02;
  // reset timing
  localparam logic [3:0] PIN_STRETCH_CYCLES = 4'hC;
  localparam logic [3:0] PIN_DRIVE_CYCLES = 4'hC;
  localparam int MCD_MIN_US = 100;
  localparam int MCD_MAX_US = 500;
  // bridge register offsets
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_DISABLE = 12'h008;
  localparam int CMD_READ_BIT = 16;
  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_hold = 3'b010,
    st_stretch = 3'b100
  } rst_state_e;
endpackage

// [logic/sfr_if.sv]
// special function register link between processor core and reset unit
// assumes both ends share pclk
`timescale 1ns/10ps
interface sfr_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic sys_reset;
  modport device (input wr, input rd, input addr, input wdata, output rdata, output sys_reset);
  modport core (output wr, output rd, output addr, output wdata, input rdata, input sys_reset);
endinterface

// [logic/core_sfr_bridge.sv]
// processor-side end: turns APB register accesses into special function register strobes
// assumes an APB master on pclk and the reset unit on the other side of sfr_if
`timescale 1ns/10ps
module core_sfr_bridge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sfr_if.core sfr
);
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic second;
  logic [1:0] rd_pend;
  logic [7:0] rdata_q;
  logic [16:0] cmd;
  logic go;

  // no new request while held in reset, mid-pair or awaiting read data
  assign go = psel & penable & ~pready & ~sfr.sys_reset & ~second & (rd_pend == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      cmd <= 17'h00000;
    end else begin
      pready <= go;
      pslverr <= 1'b0;
      if (go) begin
        prdata <= 32'h00000000;
        if (paddr == wdt_pkg::OFF_CMD) begin
          if (pwrite) begin
            cmd <= pwdata[16:0];
          end else begin
            prdata <= {15'h0000, cmd};
          end
        end else if (paddr == wdt_pkg::OFF_STATUS) begin
          if (!pwrite) begin
            prdata <= {23'h000000, sfr.sys_reset, rdata_q};
          end
        end else if (paddr != wdt_pkg::OFF_DISABLE) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // strobe generation; the disable pair goes out on back-to-back cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr <= 1'b0;
      rd <= 1'b0;
      addr <= 8'h00;
      wdata <= 8'h00;
      second <= 1'b0;
    end else begin
      wr <= 1'b0;
      rd <= 1'b0;
      if (second) begin
        wr <= 1'b1;
        wdata <= wdt_pkg::CODE_DISABLE_2; // R01 R03
        second <= 1'b0;
      end else if (go && pwrite && paddr == wdt_pkg::OFF_CMD) begin
        addr <= pwdata[15:8];
        wdata <= pwdata[7:0];
        rd <= pwdata[wdt_pkg::CMD_READ_BIT];
        wr <= ~pwdata[wdt_pkg::CMD_READ_BIT];
      end else if (go && pwrite && paddr == wdt_pkg::OFF_DISABLE) begin
        addr <= wdt_pkg::WDT_CTRL_ADDR;
        wdata <= wdt_pkg::CODE_DISABLE_1; // R01 R02
        wr <= 1'b1;
        second <= 1'b1;
      end
    end
  end

  // read data arrives one cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pend <= 2'h0;
      rdata_q <= 8'h00;
    end else begin
      rd_pend <= {rd_pend[0], rd};
      if (rd_pend[0]) begin
        rdata_q <= sfr.rdata;
      end
    end
  end

  assign sfr.wr = wr;
  assign sfr.rd = rd;
  assign sfr.addr = addr;
  assign sfr.wdata = wdata;
endmodule

// [tb/wdt_properties.sv]
// checker on the register link between the bridge and the reset unit
// assumes it sits beside the interface instance, all on pclk
`timescale 1ns/10ps
module wdt_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic sys_reset
);
  logic [2:0] interval_q;
  logic por_q;
  logic sr_q;
  logic [4:0] high_cnt;
  wire ctrl_wr = wr && !sys_reset && addr == wdt_pkg::WDT_CTRL_ADDR;
  wire cause_wr = wr && !sys_reset && addr == wdt_pkg::RESET_CAUSE_ADDR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) interval_q <= wdt_pkg::INTERVAL_RESET;
    else if (sys_reset) interval_q <= wdt_pkg::INTERVAL_RESET;
    else if (ctrl_wr && !wdata[7]) interval_q <= wdata[2:0];
  end
  // por_q clears at the first reset after power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sr_q <= 1'b1;
    else sr_q <= sys_reset;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) por_q <= 1'b1;
    else if (sys_reset && !sr_q) por_q <= 1'b0;
  end
  // saturates so a long pin hold cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) high_cnt <= 5'h00;
    else if (!sys_reset) high_cnt <= 5'h00;
    else if (high_cnt != 5'h1F) high_cnt <= high_cnt + 5'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_interval_readback: assert property (
    rd && !sys_reset && addr == wdt_pkg::WDT_CTRL_ADDR |=> rdata == {5'h00, interval_q})
    else $error("control read differs from interval");
  a_por_cause: assert property (
    rd && !sys_reset && por_q && addr == wdt_pkg::RESET_CAUSE_ADDR |=> rdata == wdt_pkg::CAUSE_RESET)
    else $error("power-on cause wrong");
  a_reset_length: assert property ($fell(sys_reset) |-> high_cnt >= 5'h0C)
    else $error("system reset too short");
  a_halted_link: assert property (sys_reset [*3] |-> !wr && !rd)
    else $error("strobe during reset");
  a_strobe_pulse: assert property (wr && wdata != wdt_pkg::CODE_DISABLE_1 |=> !wr)
    else $error("write strobe too long");
  a_pair_order: assert property (
    wr && $past(wr) |-> wdata == wdt_pkg::CODE_DISABLE_2 && $past(wdata) == wdt_pkg::CODE_DISABLE_1)
    else $error("disable pair out of order");
  a_soft_reset: assert property (cause_wr && wdata[4] |-> ##[1:4] sys_reset)
    else $error("software reset missing");
  a_forced_reset: assert property (cause_wr && wdata[0] |-> ##[1:4] sys_reset)
    else $error("forced reset missing");
  c_pair: cover property (wr ##1 wr);
  c_cause_read: cover property (rd && addr == wdt_pkg::RESET_CAUSE_ADDR);
  c_reset_end: cover property ($fell(sys_reset));
endmodule

// [tb/test_watchdog_and_reset_source_logic.sv]
// self-checking bench: APB bridge and reset unit joined by the register link
// assumes package, interface and both design ends compiled first
`timescale 1ns/10ps
module test_watchdog_and_reset_source_logic;
  localparam int tmo = 4 ** 3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_drv_n = 1'b1;
  logic [2:0] src = 3'h0;
  logic rst_pin_out;
  logic rst_pin_oe;
  logic watchdog_running;
  logic [31:0] rd_word;
  logic rd_err;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // pulled-up pin, low while either side pulls
  wire pin_level = pin_drv_n & ~rst_pin_oe;
  sfr_if sfr_if_i ();
  wdt_reset_unit #(.wdt_base_log2(6)) wdt_reset_unit_i (.pclk(pclk), .presetn(presetn), .sfr(sfr_if_i.device),
    .rst_pin_in(pin_level), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .convert_start_input(~src[0]),
    .comparator_zero(~src[1]), .missing_clock_event(src[2]), .watchdog_running(watchdog_running));
  core_sfr_bridge core_sfr_bridge_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sfr(sfr_if_i.core));
  wdt_properties wdt_properties_i (.pclk(pclk), .presetn(presetn), .wr(sfr_if_i.wr), .rd(sfr_if_i.rd),
    .addr(sfr_if_i.addr), .wdata(sfr_if_i.wdata), .rdata(sfr_if_i.rdata), .sys_reset(sfr_if_i.sys_reset));
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      $display("BAD %0t timeout", $time);
      errors = errors + 1;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // master waits on pready with no assumed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_word = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, wdt_pkg::OFF_CMD, {16'h0000, a, d});
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    apb(1'b1, wdt_pkg::OFF_CMD, {15'h0000, 1'b1, a, 8'h00});
    apb(1'b0, wdt_pkg::OFF_STATUS, 32'h00000000);
    v = rd_word[7:0];
  endtask
  task automatic wait_reset(input int lim);
    int n;
    n = 0;
    while (sfr_if_i.sys_reset !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check(n < lim, 1'b1, "reset seen");
  endtask
  task automatic t_power_on();
    logic [7:0] v;
    sfr_rd(wdt_pkg::RESET_CAUSE_ADDR, v);
    check(v, wdt_pkg::CAUSE_RESET, "por cause");
    sfr_rd(wdt_pkg::WDT_CTRL_ADDR, v);
    check(v, {5'h00, wdt_pkg::INTERVAL_RESET}, "reset interval");
    check(watchdog_running, 1'b1, "running after reset");
    apb(1'b0, wdt_pkg::OFF_CMD, 32'h00000000);
    check(rd_word, 32'h0001FF00, "command readback");
    apb(1'b0, 12'h00C, 32'h00000000);
    check(rd_err, 1'b1, "unmapped offset");
  endtask
  task automatic t_interval();
    logic [7:0] v;
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, 8'h03);
    sfr_rd(wdt_pkg::WDT_CTRL_ADDR, v);
    check(v, 8'h03, "interval set");
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, 8'h81);
    sfr_rd(wdt_pkg::WDT_CTRL_ADDR, v);
    check(v, 8'h03, "bit7 write ignored");
    // restart first so the short interval starts from a low count
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_ENABLE);
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, 8'h00);
    repeat (30) @(posedge pclk);
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_LOCK);
    repeat (tmo - 40) @(posedge pclk);
    check(sfr_if_i.sys_reset, 1'b0, "no early overflow");
    wait_reset(4);
    sfr_rd(wdt_pkg::RESET_CAUSE_ADDR, v);
    check(v, wdt_pkg::MASK_WDT, "watchdog cause");
    sfr_rd(wdt_pkg::WDT_CTRL_ADDR, v);
    check(v, 8'h07, "interval after reset");
  endtask
  task automatic t_disable();
    logic [7:0] v;
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, 8'h00);
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_ENABLE);
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_DISABLE_1);
    repeat (1) @(posedge pclk);
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_DISABLE_2);
    repeat (3) @(posedge pclk);
    check(watchdog_running, 1'b1, "late pair ignored");
    apb(1'b1, wdt_pkg::OFF_DISABLE, 32'h00000000);
    repeat (3) @(posedge pclk);
    check(watchdog_running, 1'b0, "pair disables");
    repeat (tmo * 2) @(posedge pclk);
    check(sfr_if_i.sys_reset, 1'b0, "disabled no overflow");
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_ENABLE);
    repeat (3) @(posedge pclk);
    check(watchdog_running, 1'b1, "enable code");
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_LOCK);
    apb(1'b1, wdt_pkg::OFF_DISABLE, 32'h00000000);
    repeat (3) @(posedge pclk);
    check(watchdog_running, 1'b1, "locked pair ignored");
    sfr_wr(wdt_pkg::RESET_CAUSE_ADDR, wdt_pkg::MASK_SW);
    wait_reset(8);
    check(rst_pin_oe, 1'b0, "pin left alone");
    sfr_rd(wdt_pkg::RESET_CAUSE_ADDR, v);
    check(v, wdt_pkg::MASK_SW, "software cause");
    // separate writes land four cycles apart: the widest gap still accepted
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_DISABLE_1);
    sfr_wr(wdt_pkg::WDT_CTRL_ADDR, wdt_pkg::CODE_DISABLE_2);
    repeat (3) @(posedge pclk);
    check(watchdog_running, 1'b0, "lock cleared by reset");
  endtask
  task automatic t_pin();
    logic [7:0] v;
    int n;
    pin_drv_n <= 1'b0;
    repeat (5) @(posedge pclk);
    pin_drv_n <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sfr_if_i.sys_reset === 1'b1 && n < 40);
    check(n >= 12 && n < 40, 1'b1, "pin stretch");
    sfr_rd(wdt_pkg::RESET_CAUSE_ADDR, v);
    check(v, wdt_pkg::MASK_PIN, "pin cause");
    sfr_wr(wdt_pkg::RESET_CAUSE_ADDR, wdt_pkg::MASK_PIN);
    wait_reset(8);
    repeat (2) @(posedge pclk);
    check(rst_pin_oe, 1'b1, "pin driven low");
    check(rst_pin_out, 1'b0, "pin pulls low");
    sfr_rd(wdt_pkg::RESET_CAUSE_ADDR, v);
    check(v, wdt_pkg::CAUSE_RESET, "forced cause");
  endtask
  task automatic t_sources();
    logic [7:0] m [3] = '{wdt_pkg::MASK_CNV, wdt_pkg::MASK_CMP, wdt_pkg::MASK_MCD};
    logic [7:0] v;
    // a source left disabled must not reset
    src <= 3'h2;
    repeat (10) @(posedge pclk);
    src <= 3'h0;
    check(sfr_if_i.sys_reset, 1'b0, "disabled source");
    for (int i = 0; i < 3; i++) begin
      sfr_wr(wdt_pkg::RESET_CAUSE_ADDR, m[i]);
      src <= 3'h1 << i;
      wait_reset(20);
      src <= 3'h0;
      sfr_rd(wdt_pkg::RESET_CAUSE_ADDR, v);
      check(v, m[i], "source cause");
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_power_on();
    t_interval();
    t_disable();
    t_pin();
    t_sources();
    results();
  end
endmodule
